// File: verilog/lopw_pkg.sv
// Package for the logical-OR and port-write execution block
`default_nettype none
package lopw_pkg;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned ACC_W       = 32;
  localparam int unsigned DMA_W       = 16;
  localparam int unsigned SHIFT_W     = 4;
  localparam int unsigned CNT_W       = 16;
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [31:0] ACC_RESET   = 32'h0000_0000;
  localparam logic [15:0] PORT_RESET  = 16'h0000;
  localparam logic [4:0]  ACC_SHIFT16 = 5'h10;

  // Operation selector
  typedef enum logic [2:0] {
    LOPW_OP_NONE,
    LOPW_OP_OR_MEM,
    LOPW_OP_OR_BUF,
    LOPW_OP_OR_ACC,
    LOPW_OP_PORT_WR
  } lopw_op_t;

  // Where the operand of a memory access lives
  typedef enum logic [1:0] {
    LOPW_LOC_DUAL,
    LOPW_LOC_SINGLE,
    LOPW_LOC_EXT
  } lopw_loc_t;

  // One instruction as issued by the decoder
  typedef struct packed {
    lopw_op_t          op;
    logic              has_imm;
    logic              imm_shift16;
    logic [3:0]        shift;
    logic [15:0]       imm;
    logic [15:0]       addr;
    logic [15:0]       port;
    lopw_loc_t         loc;
    logic              same_block;
    logic [15:0]       reps;
  } lopw_cmd_t;

  // Memory request toward data memory and I/O space
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        io;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lopw_mem_t;
endpackage
`default_nettype wire

// File: verilog/lopw_exec.sv
// Execution unit for memory-OR, accumulator-OR, buffer-OR and port write
// Contract
// RULE1: Memory-OR with immediate ORs it with memory
// RULE2: Memory-OR without immediate uses bit mask register
// RULE3: Memory-OR result written back to same location
// RULE4: Memory-OR leaves accumulator unchanged
// RULE5: Test flag set when result zero, else cleared
// RULE6: Buffer-OR puts accumulator OR buffer into accumulator
// RULE7: Single no-immediate external: 2+2d fetch, 5+2d+p execute
// RULE8: Single immediate external: 3+2d fetch, 6+2d+2p execute
// RULE9: Single immediate dual-access RAM: 2 fetch, 2+2p
// RULE10: Shared single-access block no-immediate: address stage 3
// RULE11: Repeated immediate shared block: address stage 2n+2
// RULE12: Repeated no-immediate external: 4n-2+2nd, 4n+1+2nd+p
// RULE13: Accumulator-OR external: 1+d fetch, 2+d+p execute
// RULE14: Repeated accumulator-OR external: n+nd, n+1+p+nd
// RULE15: Accumulator-OR zero-extends operand, ignores sign mode
// RULE16: Port write drives word out; repeat increments port
`default_nettype none
module lopw_exec (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Instruction issue
  input  wire logic                cmd_valid,
  input  wire lopw_pkg::lopw_cmd_t cmd,
  output logic                     busy,
  output logic                     done,
  // Cycle figures from the pipeline
  input  wire logic [3:0]          wait_d,
  input  wire logic [3:0]          pipe_p,
  // Memory and I/O access
  output lopw_pkg::lopw_mem_t      mem,
  input  wire logic                mem_ack,
  input  wire logic [15:0]         mem_rdata,
  // Architectural state
  input  wire logic [15:0]         bit_mask_register,
  input  wire logic [31:0]         accumulator_buffer,
  input  wire logic                sign_extension_mode,
  output logic [31:0]              acc,
  output logic                     test_flag,
  // Stage cycle figures of the last instruction
  output logic [15:0]              fetch_cycles,
  output logic [15:0]              addr_cycles,
  output logic [15:0]              exec_cycles
);
  // Sequencer states: one read and one write per repeated memory-OR or port-write word
  typedef enum logic [2:0] {
    LOPW_ST_IDLE,
    LOPW_ST_READ,
    LOPW_ST_WRITE,
    LOPW_ST_DONE
  } lopw_state_t;

  // Registered state and next values
  lopw_state_t         state, next_state;
  lopw_pkg::lopw_cmd_t cur, next_cur;
  lopw_pkg::lopw_mem_t next_mem;
  logic [31:0]         next_acc;
  logic                next_test_flag;
  logic                next_busy;
  logic                next_done;
  logic [15:0]         left, next_left;
  logic [15:0]         next_fetch_cycles;
  logic [15:0]         next_addr_cycles;
  logic [15:0]         next_exec_cycles;
  // Operand and cycle helpers
  logic [15:0]         or_word;
  logic [31:0]         acc_operand;
  logic [15:0]         n;
  logic [15:0]         nd;
  logic [15:0]         d16;
  logic [15:0]         p16;
  logic                one_rep;
  logic                code_shared;

  // Operand for accumulator-OR: zero-extended, never sign-extended
  always_comb begin
    if (cur.has_imm) begin
      if (cur.imm_shift16) begin
        acc_operand = {16'h0000, cur.imm} << lopw_pkg::ACC_SHIFT16; // [RULE15]
      end else begin
        acc_operand = {16'h0000, cur.imm} << cur.shift; // [RULE15]
      end
    end else begin
      acc_operand = {16'h0000, mem_rdata}; // [RULE15]
    end
  end

  // Second operand of memory-OR
  always_comb begin
    if (cur.has_imm) begin
      or_word = mem_rdata | cur.imm; // [RULE1]
    end else begin
      or_word = mem_rdata | bit_mask_register; // [RULE2]
    end
  end

  // Cycle figures per stage from operand location and repeat count
  always_comb begin
    n                 = (cmd.reps == 16'h0000) ? 16'h0001 : cmd.reps;
    d16               = {12'h000, wait_d};
    p16               = {12'h000, pipe_p};
    nd                = 16'(n * d16);
    one_rep           = (n == 16'h0001);
    code_shared       = (cmd.loc == lopw_pkg::LOPW_LOC_SINGLE) && cmd.same_block;
    next_fetch_cycles = n;
    next_addr_cycles  = n;
    next_exec_cycles  = 16'(n + p16);
    case (cmd.op)
      lopw_pkg::LOPW_OP_OR_MEM: begin
        if (cmd.loc == lopw_pkg::LOPW_LOC_EXT) begin
          // External operand pays the wait states on both the read and the write
          if (cmd.has_imm && one_rep) begin
            next_fetch_cycles = 16'(16'h0003 + 2 * d16); // [RULE8]
            next_exec_cycles  = 16'(16'h0006 + 2 * d16 + 2 * p16); // [RULE8]
          end else if (cmd.has_imm) begin
            next_fetch_cycles = 16'(4 * n - 1 + 2 * nd);
            next_exec_cycles  = 16'(4 * n + 2 + 2 * nd + 2 * p16);
          end else if (one_rep) begin
            next_fetch_cycles = 16'(16'h0002 + 2 * d16); // [RULE7]
            next_exec_cycles  = 16'(16'h0005 + 2 * d16 + p16); // [RULE7]
          end else begin
            next_fetch_cycles = 16'(4 * n - 2 + 2 * nd); // [RULE12]
            next_exec_cycles  = 16'(4 * n + 1 + 2 * nd + p16); // [RULE12]
          end
          next_addr_cycles = next_fetch_cycles;
        end else if (cmd.has_imm) begin
          // The immediate word costs one extra fetch per instruction
          if (one_rep) begin
            next_fetch_cycles = 16'h0002; // [RULE9]
            next_exec_cycles  = 16'(16'h0002 + 2 * p16); // [RULE9]
          end else if (cmd.loc == lopw_pkg::LOPW_LOC_SINGLE) begin
            next_fetch_cycles = 16'(2 * n - 1);
            next_exec_cycles  = 16'(2 * n - 1 + 2 * p16);
          end else begin
            next_fetch_cycles = 16'(n + 1);
            next_exec_cycles  = 16'(n + 1 + 2 * p16);
          end
          next_addr_cycles = next_fetch_cycles;
          if (!one_rep && code_shared) begin
            next_addr_cycles = 16'(2 * n + 2); // [RULE11]
          end
        end else begin
          // Single-access RAM cannot read and write back in the same cycle
          if (!one_rep && cmd.loc == lopw_pkg::LOPW_LOC_SINGLE) begin
            next_fetch_cycles = 16'(2 * n - 2);
            next_exec_cycles  = 16'(2 * n - 2 + p16);
          end
          next_addr_cycles = next_fetch_cycles;
          if (code_shared) begin
            next_addr_cycles = one_rep ? 16'h0003 : 16'(2 * n + 1); // [RULE10]
          end
        end
      end
      lopw_pkg::LOPW_OP_OR_ACC: begin
        if (cmd.has_imm) begin
          // Long immediate form is never repeated
          next_fetch_cycles = 16'h0002;
          next_addr_cycles  = 16'h0002;
          next_exec_cycles  = 16'(16'h0002 + 2 * p16);
        end else if (cmd.loc == lopw_pkg::LOPW_LOC_EXT) begin
          if (one_rep) begin
            next_fetch_cycles = 16'(16'h0001 + d16); // [RULE13]
            next_exec_cycles  = 16'(16'h0002 + d16 + p16); // [RULE13]
          end else begin
            next_fetch_cycles = 16'(n + nd); // [RULE14]
            next_exec_cycles  = 16'(n + 1 + p16 + nd); // [RULE14]
          end
          next_addr_cycles = next_fetch_cycles;
        end else if (code_shared) begin
          // Operand and code contend for one single-access block
          next_addr_cycles = 16'(n + 1);
        end
      end
      default: begin
        next_addr_cycles = n;
      end
    endcase
  end

  // Sequencer
  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_mem       = mem;
    next_acc       = acc;
    next_test_flag = test_flag;
    next_busy      = busy;
    next_done      = 1'b0;
    next_left      = left;
    case (state)
      LOPW_ST_IDLE: begin
        // A request while busy is ignored, so issue waits for done
        if (cmd_valid) begin
          next_cur  = cmd;
          next_busy = 1'b1;
          next_left = (cmd.reps == 16'h0000) ? 16'h0001 : cmd.reps;
          // Buffer-OR completes in the issue cycle
          if (cmd.op == lopw_pkg::LOPW_OP_OR_BUF) begin
            next_acc   = acc | accumulator_buffer; // [RULE6]
            next_state = LOPW_ST_DONE;
          end else if (cmd.op == lopw_pkg::LOPW_OP_OR_ACC && cmd.has_imm) begin
            next_state = LOPW_ST_WRITE;
          end else if (cmd.op == lopw_pkg::LOPW_OP_NONE) begin
            next_state = LOPW_ST_DONE;
          end else begin
            next_mem   = '{rd: 1'b1, wr: 1'b0, io: 1'b0, addr: cmd.addr,
                           wdata: lopw_pkg::DATA_RESET};
            next_state = LOPW_ST_READ;
          end
        end
      end
      // Read data stands only in the ack cycle
      LOPW_ST_READ: begin
        if (mem_ack) begin
          next_mem.rd = 1'b0;
          // Accumulator untouched; only memory and the flag move
          if (cur.op == lopw_pkg::LOPW_OP_OR_MEM) begin
            next_mem       = '{rd: 1'b0, wr: 1'b1, io: 1'b0, addr: cur.addr,
                               wdata: or_word}; // [RULE3] [RULE4]
            next_test_flag = (or_word == 16'h0000); // [RULE5]
            next_state     = LOPW_ST_WRITE;
          end else if (cur.op == lopw_pkg::LOPW_OP_PORT_WR) begin
            next_mem   = '{rd: 1'b0, wr: 1'b1, io: 1'b1, addr: cur.port,
                           wdata: mem_rdata}; // [RULE16]
            next_state = LOPW_ST_WRITE;
          end else begin
            next_acc   = acc | acc_operand; // [RULE15]
            next_state = LOPW_ST_DONE;
          end
        end
      end
      // Repeats walk the data address; port writes also walk the port
      LOPW_ST_WRITE: begin
        if (cur.op == lopw_pkg::LOPW_OP_OR_ACC) begin
          next_acc   = acc | acc_operand; // [RULE15]
          next_state = LOPW_ST_DONE;
        end else if (mem_ack) begin
          next_mem.wr = 1'b0;
          next_left   = 16'(left - 16'h0001);
          if (left == 16'h0001) begin
            next_state = LOPW_ST_DONE;
          end else begin
            next_cur.addr = 16'(cur.addr + 16'h0001);
            next_cur.port = (cur.op == lopw_pkg::LOPW_OP_PORT_WR)
                            ? 16'(cur.port + 16'h0001) : cur.port; // [RULE16]
            next_mem      = '{rd: 1'b1, wr: 1'b0, io: 1'b0,
                              addr: 16'(cur.addr + 16'h0001),
                              wdata: lopw_pkg::DATA_RESET};
            next_state    = LOPW_ST_READ;
          end
        end
      end
      // Done pulses for one cycle and busy drops with it
      LOPW_ST_DONE: begin
        next_busy  = 1'b0;
        next_done  = 1'b1;
        next_state = LOPW_ST_IDLE;
      end
      default: begin
        next_state = LOPW_ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= LOPW_ST_IDLE;
      cur       <= '0;
      mem       <= '0;
      acc       <= lopw_pkg::ACC_RESET;
      test_flag <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
      left      <= 16'h0000;
    end else begin
      state     <= next_state;
      cur       <= next_cur;
      mem       <= next_mem;
      acc       <= next_acc;
      test_flag <= next_test_flag;
      busy      <= next_busy;
      done      <= next_done;
      left      <= next_left;
    end
  end

  // Cycle figures latched when an instruction is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_cycles <= 16'h0000;
      addr_cycles  <= 16'h0000;
      exec_cycles  <= 16'h0000;
    end else if (state == LOPW_ST_IDLE && cmd_valid) begin
      fetch_cycles <= next_fetch_cycles;
      addr_cycles  <= next_addr_cycles;
      exec_cycles  <= next_exec_cycles;
    end
  end
endmodule
`default_nettype wire

// File: tb/lopw_monitor.sv
// Checker of the OR and port-write execution unit
`default_nettype none
module lopw_monitor (
  // Clock and reset
  input wire logic                clk,
  input wire logic                arst_n,
  // Issue
  input wire logic                cmd_valid,
  input wire lopw_pkg::lopw_cmd_t cmd,
  input wire logic                busy,
  input wire logic [3:0]          wait_d,
  input wire logic [3:0]          pipe_p,
  // Memory side
  input wire lopw_pkg::lopw_mem_t mem,
  input wire logic                mem_ack,
  input wire logic [15:0]         mem_rdata,
  // State
  input wire logic [15:0]         bit_mask_register,
  input wire logic [31:0]         accumulator_buffer,
  input wire logic [31:0]         acc,
  input wire logic                test_flag,
  input wire logic [15:0]         fetch_cycles,
  input wire logic [15:0]         exec_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  lopw_pkg::lopw_cmd_t cq;
  logic                take;
  logic                rdk;
  assign take = cmd_valid && !busy;
  assign rdk = mem.rd && mem_ack && cq.op == lopw_pkg::LOPW_OP_OR_MEM;
  // Instruction in flight
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cq <= '0;
    else if (take) cq <= cmd;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_hold;
    (mem.rd || mem.wr) && !mem_ack |=> $stable(mem);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_wb;
    rdk |=> mem.wr && !mem.io && mem.addr == $past(mem.addr)
      && mem.wdata == ($past(mem_rdata) | (cq.has_imm ? cq.imm : bit_mask_register));
  endproperty
  a_wb: assert property (p_wb) else $error("bad write back");
  property p_tf;
    rdk |=> test_flag == (mem.wdata == 16'h0);
  endproperty
  a_tf: assert property (p_tf) else $error("bad test flag");
  property p_acc;
    busy && cq.op == lopw_pkg::LOPW_OP_OR_MEM |=> $stable(acc);
  endproperty
  a_acc: assert property (p_acc) else $error("acc changed by memory OR");
  property p_orb;
    take && cmd.op == lopw_pkg::LOPW_OP_OR_BUF |-> ##2
      acc == ($past(acc, 2) | $past(accumulator_buffer, 2));
  endproperty
  a_orb: assert property (p_orb) else $error("bad buffer OR");
  property p_oracc;
    take && cmd.op == lopw_pkg::LOPW_OP_OR_ACC && cmd.has_imm |-> ##3
      acc == ($past(acc, 3) | ({16'h0, cq.imm} << (cq.imm_shift16 ? 5'h10 : {1'b0, cq.shift})));
  endproperty
  a_oracc: assert property (p_oracc) else $error("bad immediate OR");
  property p_cyc7;
    take && cmd.op == lopw_pkg::LOPW_OP_OR_MEM && !cmd.has_imm && cmd.reps <= 16'h1
      && cmd.loc == lopw_pkg::LOPW_LOC_EXT |=> fetch_cycles == 16'(2 + 2 * $past(wait_d))
      && exec_cycles == 16'(5 + 2 * $past(wait_d) + $past(pipe_p));
  endproperty
  a_cyc7: assert property (p_cyc7) else $error("bad external cycles");
  property p_cyc9;
    take && cmd.op == lopw_pkg::LOPW_OP_OR_MEM && cmd.has_imm && cmd.reps <= 16'h1
      && cmd.loc == lopw_pkg::LOPW_LOC_DUAL |=> fetch_cycles == 16'h2
      && exec_cycles == 16'(2 + 2 * $past(pipe_p));
  endproperty
  a_cyc9: assert property (p_cyc9) else $error("bad dual RAM cycles");
endmodule
bind lopw_exec lopw_monitor u_mon (.*);
`default_nettype wire

// File: tb/lopw_mem_model.sv
// Memory and I/O partner answering the execution unit
`default_nettype none
module lopw_mem_model (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Requests and answers
  input  wire lopw_pkg::lopw_mem_t mem,
  input  wire logic [1:0]          stall,
  output logic                     mem_ack,
  output logic [15:0]              mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ram [0:255];
  logic [31:0] io_q [$];
  logic [1:0]  dly;
  // One ack pulse per request; read data toggles when not answering
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      dly <= 2'h0;
      mem_rdata <= 16'hffff;
    end else if (!mem_ack && (mem.rd || mem.wr) && dly != 2'h0) begin
      dly <= dly - 2'h1;
      mem_rdata <= ~mem_rdata;
    end else if (!mem_ack && (mem.rd || mem.wr)) begin
      mem_ack <= 1'b1;
      dly <= stall;
      if (mem.rd) mem_rdata <= ram[mem.addr[7:0]];
      else if (mem.io) io_q.push_back({mem.addr, mem.wdata});
      else ram[mem.addr[7:0]] <= mem.wdata;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Random and corner testbench of the execution unit
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, arst_n, cmd_valid, sign_extension_mode, busy, done, mem_ack, test_flag, et;
  lopw_pkg::lopw_cmd_t cmd, c;
  lopw_pkg::lopw_mem_t mem;
  logic [3:0]          wait_d, pipe_p;
  logic [1:0]          stall;
  logic [15:0]         mem_rdata, bit_mask_register, fetch_cycles, addr_cycles, exec_cycles;
  logic [31:0]         accumulator_buffer, acc, seed, r, ea;
  logic [15:0]         er [0:255];
  int                  error_cnt, checks_done;
  lopw_exec dut (.*);
  lopw_mem_model mdl (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [47:0] cyc(lopw_pkg::lopw_cmd_t q, int d, int p);
    int n, f, a, e, i;
    logic x, s;
    n = q.reps > 16'h1 ? int'(q.reps) : 1;
    i = int'(q.has_imm);
    x = q.loc == lopw_pkg::LOPW_LOC_EXT;
    s = q.loc == lopw_pkg::LOPW_LOC_SINGLE;
    if (q.op == lopw_pkg::LOPW_OP_OR_ACC && i == 1) begin
      f = 2;
      e = 2 + 2 * p;
      a = 2;
    end else if (q.op == lopw_pkg::LOPW_OP_OR_ACC) begin
      f = x ? n + n * d : n;
      e = x ? n + 1 + p + n * d : n + p;
      a = (s && q.same_block) ? n + 1 : f;
    end else if (n == 1) begin
      f = x ? 2 + 2 * d + i : 1 + i;
      e = (x ? 5 + 2 * d : 1) + p + i * (1 + p);
      a = (s && q.same_block && i == 0) ? 3 : f;
    end else begin
      f = x ? 4 * n - 2 + 2 * n * d + i : (s ? 2 * n - 2 + i : n + i);
      e = x ? 4 * n + 1 + 2 * n * d + p + i * (1 + p) : f + p + i * p;
      a = (s && q.same_block) ? 2 * n + 1 + i : f;
    end
    return {16'(f), 16'(a), 16'(e)};
  endfunction
  task automatic chk(string n, logic [47:0] e, logic [47:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task print_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Valid is held two cycles so the second one lands while busy and must be ignored
  task automatic run();
    int k, n;
    logic [7:0] a;
    logic [47:0] ec;
    cmd = c;
    cmd_valid = 1'b1;
    ec = cyc(c, wait_d, pipe_p);
    repeat (2) @(negedge clk);
    cmd_valid = 1'b0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge clk);
    chk("done", 48'h1, {47'h0, done});
    n = c.reps > 16'h1 ? int'(c.reps) : 1;
    a = c.addr[7:0];
    if (c.op == lopw_pkg::LOPW_OP_OR_MEM) begin
      for (k = 0; k < n; k++) begin
        er[8'(a + k)] |= c.has_imm ? c.imm : bit_mask_register;
        chk("ram", {32'h0, er[8'(a + k)]}, {32'h0, mdl.ram[8'(a + k)]});
      end
      et = er[8'(a + n - 1)] == 16'h0;
    end
    if (c.op == lopw_pkg::LOPW_OP_OR_BUF) ea |= accumulator_buffer;
    if (c.op == lopw_pkg::LOPW_OP_OR_ACC && c.has_imm)
      ea |= {16'h0, c.imm} << (c.imm_shift16 ? 16 : int'(c.shift));
    if (c.op == lopw_pkg::LOPW_OP_OR_ACC && !c.has_imm) ea |= {16'h0, er[a]};
    if (c.op == lopw_pkg::LOPW_OP_OR_MEM || c.op == lopw_pkg::LOPW_OP_OR_ACC)
      chk("cycles", ec, {fetch_cycles, addr_cycles, exec_cycles});
    if (c.op == lopw_pkg::LOPW_OP_PORT_WR) begin
      chk("io count", 48'(n), 48'(mdl.io_q.size()));
      for (k = 0; k < n && mdl.io_q.size() > 0; k++)
        chk("io", {16'h0, 16'(c.port + k), er[8'(a + k)]}, {16'h0, mdl.io_q.pop_front()});
    end
    chk("acc", {16'h0, ea}, {16'h0, acc});
    chk("test flag", {47'h0, et}, {47'h0, test_flag});
    @(negedge clk);
  endtask
  initial begin
    seed = 32'h4a;
    {error_cnt, checks_done, ea, et, arst_n, cmd_valid, cmd, c} = '0;
    {wait_d, pipe_p, stall, sign_extension_mode, bit_mask_register, accumulator_buffer} = '0;
    for (int i = 0; i < 256; i++) begin
      er[i] = i[1:0] == 2'h0 ? 16'h0 : 16'(xs());
      mdl.ram[i] = er[i];
    end
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    for (int t = 0; t < 64; t++) begin
      r = xs();
      c = '0;
      c.op = lopw_pkg::lopw_op_t'({1'b0, r[1:0]} + 3'h1);
      c.has_imm = r[2];
      c.imm_shift16 = r[3];
      c.shift = r[7:4];
      c.imm = r[4] ? 16'h0 : r[31:16];
      c.addr = {8'h0, r[15:8]};
      c.port = r[31:16];
      c.loc = r[17] ? lopw_pkg::LOPW_LOC_EXT : lopw_pkg::lopw_loc_t'({1'b0, r[16]});
      c.same_block = r[18];
      c.reps = (r[21] == 1'b1) ? 16'h1 : {14'h0, r[20:19]} + 16'h1;
      wait_d = r[23:20];
      pipe_p = r[27:24];
      stall = r[31:30];
      sign_extension_mode = r[29];
      bit_mask_register = r[28] ? 16'h0 : 16'(xs());
      accumulator_buffer = xs();
      // Zero results on untouched zero words, single external and dual RAM forms
      if (t < 4) begin
        c.op = lopw_pkg::LOPW_OP_OR_MEM;
        c.reps = {15'h0, t[0]};
        c.loc = t[1] ? lopw_pkg::LOPW_LOC_EXT : lopw_pkg::LOPW_LOC_DUAL;
        c.has_imm = t[0];
        c.imm = 16'h0;
        c.addr = 16'(4 * t + 4);
        bit_mask_register = 16'h0;
      end
      if (t == 4) c.op = lopw_pkg::LOPW_OP_NONE;
      run();
    end
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
